// [core/ssm_core.sv]
// Synchronous serial port: master receive and slave transmit paths, APB slave
// Assumes one 20 MHz pclk; serial pins come from outside and are synchronised
// Notes on behaviour
// - Receive starts only when single or continuous set
// - Master samples data on shift clock trailing edge
// - Single receive takes exactly one word
// - Continuous receive repeats until software clears
// - Both enables set behaves as continuous
// - Word done sets flag; irq if enabled
// - Clearing continuous enable clears receive errors
// - Ninth bit and error shown in status
// - Low eight bits in receive buffer
// - Clock source clear selects slave mode
// - Slave shifts on external clock pin
// - Slave keeps working while chip sleeps
// - Second queued word stays buffered, flag clear
// - Second word moves to shifter, flag sets
// - Transmit flag with enable wakes the chip
// - Master drives clock, idle from polarity
// - Half duplex: receive and transmit exclusive
// - Transmit flag clears only on buffer write
`timescale 1ns/10ps
`include "ssm_params.svh"

module ssm_core #(
    parameter int DIV_WIDTH = 16 // Divider width with wide select
) (
    input wire logic pclk, // System clock, 20 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shift_clock_pin_i, // Clock pin level
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe, // High while master drives clock
    input wire logic serial_data_pin_i, // Data pin level
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe, // High while slave transmits
    output logic irq, // Interrupt request, also wakes the chip
    input wire logic sleep_i // Chip is in a low-power mode
);
    import ssm_pkg::*;

    // ----------
    // Registers
    // ----------
    logic [7:0] rx_ctl_reg; // Writable receive control bits
    logic [7:0] rx_buf_reg; // Received low byte
    logic rx_bit9_reg; // Received ninth bit
    logic overrun_reg; // Word lost while buffer full
    logic [7:0] tx_ctl_reg; // Writable transmit control bits
    logic [7:0] baud_reg; // Polarity and wide divider select
    logic [7:0] div_hi_reg;
    logic [7:0] div_lo_reg;
    logic [7:0] tx_buf_reg; // Transmit holding byte
    logic tx_buf_bit9_reg; // Ninth bit captured with holding byte
    logic tx_buf_full_reg; // Holding byte waits for shifter
    logic rx_flag_reg; // Receive buffer holds unread word
    logic [1:0] irq_en_reg; // Receive and transmit irq enables

    // Decoded control
    logic port_en, sync_mode, master, single_en, cont_en, rx_nine, tx_nine, tx_en;
    assign port_en = rx_ctl_reg[`SSM_RX_PORT_EN];
    assign sync_mode = tx_ctl_reg[`SSM_TX_SYNC];
    assign master = tx_ctl_reg[`SSM_TX_CLKSRC];
    assign single_en = rx_ctl_reg[`SSM_RX_SINGLE];
    assign cont_en = rx_ctl_reg[`SSM_RX_CONT];
    assign rx_nine = rx_ctl_reg[`SSM_RX_NINE];
    assign tx_nine = tx_ctl_reg[`SSM_TX_NINE];
    assign tx_en = tx_ctl_reg[`SSM_TX_EN];

    logic active; // Port enabled in synchronous mode
    assign active = port_en && sync_mode;

    // Address match helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic wr, rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1; // Zero wait states
    assign pslverr = 1'b0;

    // ----------
    // Pin synchronisers
    // ----------
    logic [1:0] ck_sync, dt_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_sync <= 2'h0;
            dt_sync <= 2'h0;
        end else begin
            ck_sync <= {ck_sync[0], shift_clock_pin_i};
            dt_sync <= {dt_sync[0], serial_data_pin_i};
        end
    end
    logic ck_prev_reg; // For external edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg <= ck_sync[1];
        end
    end
    // External clock edges, corrected for idle polarity
    logic ext_lead, ext_trail, pol;
    assign pol = baud_reg[`SSM_BAUD_POL];
    assign ext_lead = (ck_sync[1] ^ pol) && !(ck_prev_reg ^ pol);
    assign ext_trail = !(ck_sync[1] ^ pol) && (ck_prev_reg ^ pol);

    // ----------
    // Baud divider: one-cycle half-period tick
    // ----------
    logic [DIV_WIDTH-1:0] div_cnt_reg, div_load;
    logic tick;
    assign div_load = baud_reg[`SSM_BAUD_WIDE] ? {div_hi_reg, div_lo_reg}
                                               : {8'h00, div_lo_reg};
    assign tick = (div_cnt_reg == '0);
    logic [1:0] rx_state_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= '0;
        end else if (tick || !active) begin
            div_cnt_reg <= div_load;
        end else begin
            div_cnt_reg <= div_cnt_reg - 1'b1;
        end
    end

    // ----------
    // Master receive sequencer
    // ----------
    ssm_rx_state_t rx_state;
    logic [3:0] rx_cnt_reg; // Bits received in current word
    logic [8:0] rx_shift_reg;
    logic tx_busy; // Slave shifter holds a word
    logic rx_go, rx_done, clk_level_reg;
    logic [3:0] rx_bits;
    assign rx_bits = rx_nine ? 4'h9 : 4'h8;
    // Either enable starts a word, once the slave shifter is not busy
    assign rx_go = active && master && (single_en || cont_en) && !tx_busy;
    assign rx_done = (rx_state == SSM_RX_HIGH) && tick && (rx_cnt_reg == rx_bits - 4'h1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= SSM_RX_IDLE;
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
            clk_level_reg <= 1'b0;
        end else begin
            case (rx_state)
                SSM_RX_IDLE: begin
                    clk_level_reg <= 1'b0;
                    rx_cnt_reg <= 4'h0;
                    if (rx_go && tick) begin
                        rx_state <= SSM_RX_HIGH; // Leading clock edge
                        clk_level_reg <= 1'b1;
                    end
                end
                SSM_RX_HIGH: begin
                    if (!active || !master) begin
                        rx_state <= SSM_RX_IDLE;
                    end else if (tick) begin
                        // Trailing (falling) edge: sample data
                        clk_level_reg <= 1'b0;
                        rx_shift_reg <= {dt_sync[1], rx_shift_reg[8:1]}; // LSB first
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        rx_state <= SSM_RX_LOW;
                    end
                end
                SSM_RX_LOW: begin
                    if (!active || !master) begin
                        rx_state <= SSM_RX_IDLE;
                    end else if (tick) begin
                        if (rx_cnt_reg == rx_bits) begin
                            // Continuous goes on, single stops
                            rx_cnt_reg <= 4'h0;
                            if (cont_en) begin
                                clk_level_reg <= 1'b1;
                                rx_state <= SSM_RX_HIGH;
                            end else begin
                                rx_state <= SSM_RX_IDLE;
                            end
                        end else begin
                            clk_level_reg <= 1'b1;
                            rx_state <= SSM_RX_HIGH;
                        end
                    end
                end
                default: rx_state <= SSM_RX_IDLE;
            endcase
        end
    end
    assign rx_state_reg = rx_state;

    // Clock pin: master drives it, idle level from polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_clock_pin_o <= 1'b0;
            shift_clock_pin_oe <= 1'b0;
        end else begin
            shift_clock_pin_o <= clk_level_reg ^ pol;
            shift_clock_pin_oe <= active && master;
        end
    end

    // Word captured at end of last bit
    logic rx_word_done;
    logic [7:0] rx_byte;
    logic rx_b9;
    assign rx_word_done = (rx_state == SSM_RX_HIGH) && tick && active && master
                          && (rx_cnt_reg == rx_bits - 4'h1);
    // Final shift includes the last sample
    assign rx_byte = rx_nine ? rx_shift_reg[8:1] : {dt_sync[1], rx_shift_reg[8:2]};
    assign rx_b9 = dt_sync[1];

    // ----------
    // Receive buffer, flag, ninth bit, overrun
    // ----------
    logic rx_buf_read;
    assign rx_buf_read = rd && hit(paddr, `SSM_OFF_RXBUF);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_reg <= `SSM_RST_BYTE;
            rx_bit9_reg <= 1'b0;
            rx_flag_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            if (rx_word_done && rx_flag_reg && !rx_buf_read) begin
                overrun_reg <= 1'b1; // Unread word kept, new one lost
            end else if (!cont_en || !port_en) begin
                overrun_reg <= 1'b0;
            end
            if (rx_word_done && !(rx_flag_reg && !rx_buf_read)) begin
                rx_buf_reg <= rx_byte;
                rx_bit9_reg <= rx_nine ? rx_b9 : 1'b0;
                rx_flag_reg <= 1'b1; // Set wins over read
            end else if (rx_buf_read) begin
                rx_flag_reg <= 1'b0;
            end
        end
    end

    // ----------
    // Slave transmit: holding byte and shifter on external clock
    // ----------
    logic [8:0] tsr_reg; // Transmit shift register
    logic [3:0] tx_cnt_reg; // Bits left in shifter
    logic tx_flag_reg;
    logic tx_buf_write;
    assign tx_buf_write = wr && hit(paddr, `SSM_OFF_TXBUF);
    assign tx_busy = (tx_cnt_reg != 4'h0);
    // Shifting runs off the pin clock, so sleep_i is not consulted
    logic slave_tx, tx_load;
    assign slave_tx = active && !master && tx_en && !single_en && !cont_en;
    assign tx_load = slave_tx && tx_buf_full_reg
                     && (!tx_busy || (tx_cnt_reg == 4'h1 && ext_trail));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsr_reg <= 9'h000;
            tx_cnt_reg <= 4'h0;
            serial_data_pin_o <= 1'b0;
        end else if (!slave_tx) begin
            tx_cnt_reg <= 4'h0;
        end else if (tx_load) begin
            // Holding byte moves into shifter
            tsr_reg <= {tx_buf_bit9_reg, tx_buf_reg};
            tx_cnt_reg <= tx_nine ? 4'h9 : 4'h8;
        end else if (tx_busy && ext_lead) begin
            serial_data_pin_o <= tsr_reg[0]; // Present bit on leading edge
        end else if (tx_busy && ext_trail) begin
            tsr_reg <= {1'b0, tsr_reg[8:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
        end
    end
    assign serial_data_pin_oe = slave_tx && tx_busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_reg <= `SSM_RST_BYTE;
            tx_buf_bit9_reg <= 1'b0;
            tx_buf_full_reg <= 1'b0;
            tx_flag_reg <= 1'b0;
        end else begin
            if (tx_buf_write) begin
                // Ninth bit latched now, so it must be written first
                tx_buf_reg <= pwdata[7:0];
                tx_buf_bit9_reg <= tx_ctl_reg[`SSM_TX_BIT9];
                tx_buf_full_reg <= 1'b1;
                tx_flag_reg <= 1'b0; // Only clear path
            end else if (tx_load) begin
                tx_buf_full_reg <= 1'b0;
                tx_flag_reg <= 1'b1;
            end
        end
    end

    // Request wakes the chip when enabled
    assign irq = (rx_flag_reg && irq_en_reg[0]) || (tx_flag_reg && irq_en_reg[1]);

    // ----------
    // Control register writes
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ctl_reg <= `SSM_RST_BYTE;
            tx_ctl_reg <= `SSM_RST_BYTE;
            baud_reg <= `SSM_RST_BYTE;
            div_hi_reg <= `SSM_RST_BYTE;
            div_lo_reg <= `SSM_RST_BYTE;
            irq_en_reg <= 2'h0;
        end else begin
            if (wr && hit(paddr, `SSM_OFF_RXCTL)) begin
                rx_ctl_reg <= {pwdata[7:4], 4'h0};
            end else if (rx_done && !cont_en) begin
                rx_ctl_reg[`SSM_RX_SINGLE] <= 1'b0;
            end
            if (wr && hit(paddr, `SSM_OFF_TXCTL)) begin
                tx_ctl_reg <= {pwdata[7:4], 3'h0, pwdata[0]};
            end
            if (wr && hit(paddr, `SSM_OFF_BAUD)) begin
                baud_reg <= {3'h0, pwdata[4:3], 3'h0};
            end
            if (wr && hit(paddr, `SSM_OFF_DIVH)) begin
                div_hi_reg <= pwdata[7:0];
            end
            if (wr && hit(paddr, `SSM_OFF_DIVL)) begin
                div_lo_reg <= pwdata[7:0];
            end
            if (wr && hit(paddr, `SSM_OFF_IRQ)) begin
                irq_en_reg <= pwdata[3:2];
            end
        end
    end

    // ----------
    // Read mux, unmapped reads return zero
    // ----------
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit(paddr, `SSM_OFF_RXCTL)) begin
            prdata[7:0] = {rx_ctl_reg[7:4], 2'h0, overrun_reg, rx_bit9_reg};
        end else if (hit(paddr, `SSM_OFF_RXBUF)) begin
            prdata[7:0] = rx_buf_reg;
        end else if (hit(paddr, `SSM_OFF_TXCTL)) begin
            prdata[7:0] = {tx_ctl_reg[7:4], 2'h0, !tx_busy, tx_ctl_reg[0]};
        end else if (hit(paddr, `SSM_OFF_BAUD)) begin
            prdata[7:0] = baud_reg;
        end else if (hit(paddr, `SSM_OFF_DIVH)) begin
            prdata[7:0] = div_hi_reg;
        end else if (hit(paddr, `SSM_OFF_DIVL)) begin
            prdata[7:0] = div_lo_reg;
        end else if (hit(paddr, `SSM_OFF_TXBUF)) begin
            prdata[7:0] = tx_buf_reg;
        end else if (hit(paddr, `SSM_OFF_IRQ)) begin
            prdata[7:0] = {4'h0, irq_en_reg, tx_flag_reg, rx_flag_reg};
        end
    end
endmodule

// [core/ssm_params.svh]
// Register offsets, field positions and reset values
// Assumes APB byte addresses, one 32-bit word per register
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

// ----------
// Register byte offsets
// ----------
`define SSM_OFF_RXCTL 8'h00
`define SSM_OFF_RXBUF 8'h04
`define SSM_OFF_TXCTL 8'h08
`define SSM_OFF_BAUD 8'h0C
`define SSM_OFF_DIVH 8'h10
`define SSM_OFF_DIVL 8'h14
`define SSM_OFF_TXBUF 8'h18
`define SSM_OFF_IRQ 8'h1C

// ----------
// Field positions
// ----------
// Receive status/control
`define SSM_RX_PORT_EN 7
`define SSM_RX_NINE 6
`define SSM_RX_SINGLE 5
`define SSM_RX_CONT 4
`define SSM_RX_OVERRUN 1
`define SSM_RX_BIT9 0
// Transmit status/control
`define SSM_TX_CLKSRC 7
`define SSM_TX_NINE 6
`define SSM_TX_EN 5
`define SSM_TX_SYNC 4
`define SSM_TX_EMPTY 1
`define SSM_TX_BIT9 0
// Baud control
`define SSM_BAUD_POL 4
`define SSM_BAUD_WIDE 3
// Flags and enables register
`define SSM_IRQ_RXF 0
`define SSM_IRQ_TXF 1
`define SSM_IRQ_RXE 2
`define SSM_IRQ_TXE 3

// ----------
// Reset values
// ----------
`define SSM_RST_BYTE 8'h00

`endif

// [core/ssm_pkg.sv]
// Types shared by the synchronous serial block
// Assumes the constants header is included by the design file
package ssm_pkg;
    // Master receive sequencer
    typedef enum logic [1:0] {
        SSM_RX_IDLE,
        SSM_RX_LOW,
        SSM_RX_HIGH
    } ssm_rx_state_t;
endpackage

// [testbench/ssm_core_properties.sv]
// Checker for the synchronous serial block, watching top-level ports only
// Assumes zero-wait APB and the offsets of the constants header
`timescale 1ns/10ps
`include "ssm_params.svh"

module ssm_core_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic shift_clock_pin_i,
    input wire logic shift_clock_pin_o,
    input wire logic shift_clock_pin_oe,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_pin_oe,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------
    // Mirrors of register bits as software last wrote them
    // ----------
    logic [7:0] m_rx, m_tx, m_bd, m_dl, m_ie; // Register mirrors
    logic seen; // Some receive enable written since reset
    logic [7:0] hcnt; // Cycles since the clock pin last moved
    logic mst; // Master mode selected
    assign mst = m_rx[7] && m_tx[7] && m_tx[4];
    // Mirrors track completed APB writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {m_rx, m_tx, m_bd, m_dl, m_ie} <= '0;
            seen <= 1'b0;
        end else if (psel && penable && pwrite && pready) begin
            case (paddr)
                `SSM_OFF_RXCTL: begin
                    m_rx <= pwdata[7:0];
                    seen <= seen | pwdata[5] | pwdata[4];
                end
                `SSM_OFF_TXCTL: m_tx <= pwdata[7:0];
                `SSM_OFF_BAUD: m_bd <= pwdata[7:0];
                `SSM_OFF_DIVL: m_dl <= pwdata[7:0];
                `SSM_OFF_IRQ: m_ie <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    // Saturating, so a long idle never looks like a short phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcnt <= 8'hFF;
        end else if ($changed(shift_clock_pin_o)) begin
            hcnt <= 8'h00;
        end else if (hcnt != 8'hFF) begin
            hcnt <= hcnt + 8'h01;
        end
    end
    // ----------
    // Properties
    // ----------
    a_clk_follows_cfg: assert property (shift_clock_pin_oe == $past(mst))
        else $error("clock drive does not follow mode bits");
    a_clk_idle_pol: assert property ((mst && !seen && $stable(m_bd[4]))[*2]
        |-> shift_clock_pin_o == m_bd[4]) else $error("clock left idle level");
    a_half_min: assert property (shift_clock_pin_oe && $past(shift_clock_pin_oe)
        && $changed(shift_clock_pin_o) && $stable(m_bd[4]) |-> hcnt >= m_dl)
        else $error("clock phase too short");
    a_active_max: assert property (shift_clock_pin_oe && (m_rx[4] || m_rx[5])
        && shift_clock_pin_o != m_bd[4] && !$changed(shift_clock_pin_o)
        && $stable(m_bd[4]) |-> hcnt < m_dl) else $error("clock phase too long");
    a_half_duplex: assert property (serial_data_pin_oe |-> !shift_clock_pin_oe)
        else $error("data and clock driven together");
    a_irq_needs_en: assert property (m_ie[3:2] == 2'b00 |-> !irq)
        else $error("irq without enable");
    a_slave_hold: assert property ((!psel && !mst
        && $stable({shift_clock_pin_i, serial_data_pin_oe}))[*6]
        |-> $stable(serial_data_pin_o)) else $error("data moved without clock");
    a_read_clean: assert property (psel && penable && !pwrite
        |-> pready && prdata[31:8] == 24'h000000) else $error("bad read word");
    c_irq: cover property ($rose(irq));
    c_slave: cover property ($rose(serial_data_pin_oe));
    c_master: cover property ($rose(shift_clock_pin_oe));
endmodule

bind ssm_core ssm_core_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .shift_clock_pin_i(shift_clock_pin_i),
    .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe(shift_clock_pin_oe),
    .serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe(serial_data_pin_oe),
    .irq(irq));

// [testbench/ssm_partner.sv]
// External synchronous device: feeds words to the master, clocks the slave
// Assumes the bench resolves both pins; its clock stands still between bursts
`timescale 1ns/10ps

module ssm_partner (
    input wire logic pclk,
    input wire logic ck_i,
    input wire logic dt_i,
    input wire logic pol,
    input wire logic [8:0] word,
    input wire logic [3:0] nbits,
    input wire logic go,
    output logic ck_o,
    output logic dt_o,
    output logic [8:0] got,
    output logic busy
);
    logic ck_q; // Last clock pin level
    int idx; // Next bit of word to present
    // Next bit goes out as the clock leaves idle, so it is steady when sampled
    always @(posedge pclk) begin
        ck_q <= ck_i;
        if (go) begin
            idx <= 0;
        end else if (ck_i != pol && ck_q == pol) begin
            dt_o <= word[idx];
            idx <= (idx == nbits - 1) ? 0 : idx + 1;
        end
    end
    // Burst of clocks; slave bit captured just before each trailing edge
    initial begin
        busy = 1'b0;
        got = '0;
        forever begin
            @(posedge pclk);
            if (go && nbits != 4'd0) begin
                busy <= 1'b1;
                for (int i = 0; i < nbits; i++) begin
                    ck_o <= ~pol;
                    repeat (6) @(posedge pclk);
                    got[i] <= dt_i;
                    ck_o <= pol;
                    repeat (6) @(posedge pclk);
                end
                busy <= 1'b0;
            end else begin
                ck_o <= pol;
            end
        end
    end
endmodule

// [testbench/tb_ssm_core.sv]
// Self-checking bench: APB master, pin resolution, partner device
// Assumes zero-wait APB slave and a 20 MHz pclk
`timescale 1ns/10ps
`include "ssm_params.svh"

module tb_ssm_core;
    import ssm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sleep_i;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata;
    logic ck_o, ck_oe, dt_o, dt_oe, p_ck, p_dt, ck_w, dt_w, ck_q, go, pol, busy;
    logic [8:0] word, got;
    logic [3:0] nbits;
    int mismatches, comparisons, edges, e0;
    // Wire levels from the core's enables; the partner drives otherwise
    assign ck_w = ck_oe ? ck_o : p_ck;
    assign dt_w = dt_oe ? dt_o : p_dt;
    ssm_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shift_clock_pin_i(ck_w), .shift_clock_pin_o(ck_o),
        .shift_clock_pin_oe(ck_oe), .serial_data_pin_i(dt_w), .serial_data_pin_o(dt_o),
        .serial_data_pin_oe(dt_oe), .irq(irq), .sleep_i(sleep_i));
    ssm_partner u_far (.pclk(pclk), .ck_i(ck_w), .dt_i(dt_w), .pol(pol), .word(word),
        .nbits(nbits), .go(go), .ck_o(p_ck), .dt_o(p_dt), .got(got), .busy(busy));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Counts master clock transitions
    always @(posedge pclk) begin
        ck_q <= ck_o;
        if (ck_oe === 1'b1 && ck_o !== ck_q) edges <= edges + 1;
    end
    // ----------
    // Shared tasks
    // ----------
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; an idle edge after it keeps drivers single per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata[7:0];
        chk("slave error", {8'h00, pslverr}, 9'h000);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string what);
        apb(1'b0, a, 8'h00);
        chk(what, {1'b0, q & m}, {1'b0, e});
    endtask
    task automatic wait_irq(input logic lvl);
        for (int n = 0; n < 2000 && irq !== lvl; n++) @(posedge pclk);
    endtask
    // Arms the partner; a bit count of zero only rewinds its word
    task automatic arm(input logic [8:0] w, input logic [3:0] n);
        word <= w;
        nbits <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        repeat (8) @(posedge pclk);
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_reset();
        rd(`SSM_OFF_RXCTL, 8'hFF, 8'h00, "rxctl at reset");
        rd(`SSM_OFF_IRQ, 8'hFF, 8'h00, "flags at reset");
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'hFF, 8'h00, "unmapped");
    endtask
    task automatic t_single();
        arm(9'h0A5, 4'd0);
        nbits <= 4'd8;
        wr(`SSM_OFF_DIVL, 8'h05);
        wr(`SSM_OFF_RXCTL, 8'h80);
        wr(`SSM_OFF_TXCTL, 8'h90);
        wr(`SSM_OFF_IRQ, 8'h04);
        e0 = edges;
        repeat (20) @(posedge pclk);
        chk("clock before enable", 9'(edges - e0), 9'd0);
        wr(`SSM_OFF_RXCTL, 8'hA0);
        wait_irq(1'b1);
        chk("rx irq", {8'h00, irq}, 9'h001);
        rd(`SSM_OFF_RXCTL, 8'hFF, 8'h80, "single self clear");
        rd(`SSM_OFF_IRQ, 8'hFF, 8'h05, "rx flag");
        rd(`SSM_OFF_RXBUF, 8'hFF, 8'hA5, "single word");
        repeat (100) @(posedge pclk);
        chk("one word of clocks", 9'(edges - e0), 9'd16);
        chk("irq after read", {8'h00, irq}, 9'h000);
    endtask
    // Mid-run reset, inverted idle level, nine bits, both enables
    task automatic t_cont();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        pol <= 1'b1;
        arm(9'h15A, 4'd0);
        nbits <= 4'd9;
        wr(`SSM_OFF_BAUD, 8'h10);
        wr(`SSM_OFF_DIVL, 8'h05);
        wr(`SSM_OFF_RXCTL, 8'hC0);
        wr(`SSM_OFF_TXCTL, 8'h90);
        wr(`SSM_OFF_IRQ, 8'h04);
        chk("idle high", {8'h00, ck_w}, 9'h001);
        wr(`SSM_OFF_RXCTL, 8'hF0);
        wait_irq(1'b1);
        rd(`SSM_OFF_RXCTL, 8'h51, 8'h51, "ninth bit");
        rd(`SSM_OFF_RXBUF, 8'hFF, 8'h5A, "low byte");
        wait_irq(1'b1);
        rd(`SSM_OFF_RXBUF, 8'hFF, 8'h5A, "second word");
        wait_irq(1'b1);
        repeat (130) @(posedge pclk);
        rd(`SSM_OFF_RXCTL, 8'h02, 8'h02, "overrun");
        wr(`SSM_OFF_RXCTL, 8'hC0);
        rd(`SSM_OFF_RXCTL, 8'h12, 8'h00, "error cleared");
    endtask
    // Two words queued while asleep, external clock only
    task automatic t_slave();
        wr(`SSM_OFF_RXCTL, 8'h80);
        wr(`SSM_OFF_TXCTL, 8'h71);
        wr(`SSM_OFF_IRQ, 8'h08);
        sleep_i <= 1'b1;
        wr(`SSM_OFF_TXBUF, 8'h3C);
        wr(`SSM_OFF_TXBUF, 8'hC3);
        rd(`SSM_OFF_IRQ, 8'h02, 8'h00, "flag held clear");
        rd(`SSM_OFF_TXCTL, 8'h02, 8'h00, "shifter busy");
        chk("no wake yet", {8'h00, irq}, 9'h000);
        arm(9'h000, 4'd9);
        chk("first word", got, 9'h13C);
        rd(`SSM_OFF_IRQ, 8'h02, 8'h02, "flag on reload");
        chk("wake", {8'h00, irq}, 9'h001);
        wr(`SSM_OFF_IRQ, 8'h08);
        rd(`SSM_OFF_IRQ, 8'h02, 8'h02, "flag not cleared");
        arm(9'h000, 4'd9);
        chk("second word", got, 9'h1C3);
        rd(`SSM_OFF_TXCTL, 8'h02, 8'h02, "shifter empty");
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Whole run is about a thousand cycles; this margin means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_sim();
    end
    initial begin
        {presetn, psel, penable, pwrite, go, pol, sleep_i} = '0;
        {paddr, pwdata, word, nbits, edges, ck_q} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_single();
        t_cont();
        t_slave();
        end_sim();
    end
endmodule
